// [rtl/lpmc_pkg.sv]
// lpmc_pkg: register map, field positions, reset values, timing and states
// for the low power mode controller; assumes a 25 MHz system clock.
package lpmc_pkg;
    // register byte offsets
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_FSMR = 5'h04;
    localparam logic [4:0] ADDR_WKUP = 5'h08;
    localparam logic [4:0] ADDR_PCER = 5'h0C;
    localparam logic [4:0] ADDR_STAT = 5'h10;
    localparam logic [4:0] ADDR_ISR = 5'h14;
    localparam logic [4:0] ADDR_IMR = 5'h18;
    // field positions
    localparam int CTRL_DEEP_BIT = 0;
    localparam int CTRL_CSEL_LSB = 1;
    localparam int CTRL_RCEN_BIT = 3;
    localparam int FSMR_RTT_BIT = 16;
    localparam int FSMR_RTC_BIT = 17;
    localparam int FSMR_LPM_BIT = 20;
    localparam int WKUP_SM_BIT = 16;
    localparam int WKUP_RTC_BIT = 17;
    localparam int WKUP_RTT_BIT = 18;
    localparam int WKUP_DEB_LSB = 24;
    localparam int STAT_WFI_BIT = 8;
    localparam int ISR_SLEEP_BIT = 0;
    localparam int ISR_WAIT_BIT = 1;
    localparam int ISR_BKP_BIT = 2;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    localparam logic [31:0] FSMR_RST = 32'h0000_0000;
    localparam logic [31:0] WKUP_RST = 32'h0000_0000;
    localparam logic [7:0] PCER_RST = 8'h00;
    localparam logic [2:0] IMR_RST = 3'h0;
    // main clock source codes
    localparam logic [1:0] CSEL_FAST_RC = 2'h0;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int WAIT_RESUME_NS = 10000;
    localparam int BKP_WAKE_NS = 100000;
    localparam logic [11:0] WRES_CYC = 12'((WAIT_RESUME_NS / CLK_PERIOD_NS) - 1);
    localparam logic [11:0] BKP_CYC = 12'((BKP_WAKE_NS / CLK_PERIOD_NS) - 1);
    localparam logic [11:0] RESYNC_CYC = 12'h004;
    // controller states, one-hot
    typedef enum logic [6:0] {
        ST_ACTIVE = 7'b000_0001,
        ST_SLEEP = 7'b000_0010,
        ST_WSYNC = 7'b000_0100,
        ST_WAIT = 7'b000_1000,
        ST_WRES = 7'b001_0000,
        ST_BACKUP = 7'b010_0000,
        ST_BWAKE = 7'b100_0000
    } lpmc_state_t;
endpackage : lpmc_pkg

// [rtl/lpmc_debounce.sv]
// lpmc_debounce: one wake-up pin filter, pulses on a stable level change.
// assumes the pin is synchronous to i_clk and idles low after reset.
`timescale 1ns/10ps
module lpmc_debounce (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // pin and filter length
    input wire logic i_pin,
    input wire logic [3:0] i_len,
    // level change event
    output logic o_evt
);
    logic stable_ff;
    logic [3:0] cnt_ff;
    logic evt_ff;
    wire differ = i_pin != stable_ff;
    wire settled = differ && (cnt_ff >= i_len);

    // count cycles the pin differs from the accepted level
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stable_ff <= 1'b0;
            cnt_ff <= 4'h0;
            evt_ff <= 1'b0;
        end else if (i_ce) begin
            stable_ff <= settled ? i_pin : stable_ff;
            cnt_ff <= (differ && !settled) ? cnt_ff + 4'h1 : 4'h0;
            evt_ff <= settled;
        end
    end
    assign o_evt = evt_ff;
endmodule : lpmc_debounce

// [rtl/lpmc_timer.sv]
// lpmc_timer: down counter that pulses done when a loaded count expires.
// assumes start is a one-cycle pulse and load is at least one.
`timescale 1ns/10ps
module lpmc_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // control
    input wire logic i_start,
    input wire logic [11:0] i_load,
    // expiry pulse
    output logic o_done
);
    logic [11:0] cnt_ff;
    logic done_ff;

    // load on start, count down, flag the last step
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_ff <= 12'h000;
            done_ff <= 1'b0;
        end else if (i_ce) begin
            cnt_ff <= i_start ? i_load : (cnt_ff != 12'h000 ? cnt_ff - 12'h001 : cnt_ff);
            done_ff <= !i_start && (cnt_ff == 12'h002 || (cnt_ff == 12'h001 && !done_ff));
        end
    end
    assign o_done = done_ff;
endmodule : lpmc_timer

// [rtl/lpmc_top.sv]
// lpmc_top: low power mode controller with an Avalon-MM register slave.
// assumes sleep instruction strobes are one-cycle pulses from the core and
// that all inputs are synchronous to i_clk.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module lpmc_top
    import lpmc_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // avalon-mm slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // core sleep instructions and wake causes
    input wire logic i_wfe,
    input wire logic i_wfi,
    input wire logic i_irq_pending,
    input wire logic i_event,
    // wake sources
    input wire logic [15:0] i_wakeup_pins,
    input wire logic i_sm_alarm,
    input wire logic i_rtc_alarm,
    input wire logic i_rtt_alarm,
    // clock and power control
    output logic o_core_clk_en,
    output logic o_mem_clk_en,
    output logic [7:0] o_periph_clk_en,
    output logic [1:0] o_clk_src,
    output logic o_regulator_en,
    output logic o_core_supply_en,
    output logic o_backup_dom_en,
    // core reset and i/o control
    output logic o_core_rst,
    output logic o_io_hold,
    output logic o_io_pullup_force,
    // interrupt
    output logic o_irq
);
    localparam int WRES_MAX = 249;
    lpmc_state_t st_ff, nxt_st;
    logic [31:0] ctrl_ff, fsmr_ff, wkup_ff;
    logic [7:0] pcer_ff;
    logic [2:0] isr_ff, imr_ff;
    logic wfi_entry_ff;
    logic [11:0] bwk_cnt_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic core_clk_ff, mem_clk_ff, reg_ff, sup_ff, rst_ff, hold_ff, pull_ff;
    logic irq_ff;
    logic [7:0] pclk_ff;
    logic [1:0] csrc_ff;
    logic [15:0] pin_evt;
    logic resync_done, wres_done, bkp_done;

    // bus decode
    wire req = i_avs_read || i_avs_write;
    wire take = req && !wait_ff;
    wire wr = take && i_avs_write;
    wire [4:0] adr = {i_avs_address[4:2], 2'b00};
    wire wr_ctrl = wr && adr == ADDR_CTRL;
    wire wr_fsmr = wr && adr == ADDR_FSMR;
    wire wr_wkup = wr && adr == ADDR_WKUP;
    wire wr_pcer = wr && adr == ADDR_PCER;
    wire wr_isr = wr && adr == ADDR_ISR;
    wire wr_imr = wr && adr == ADDR_IMR;

    // control fields
    wire deep = ctrl_ff[CTRL_DEEP_BIT];
    wire low_power_mode_bit = fsmr_ff[FSMR_LPM_BIT];
    wire [1:0] csel = ctrl_ff[CTRL_CSEL_LSB +: 2];
    wire [3:0] deb_len = wkup_ff[WKUP_DEB_LSB +: 4];

    // wake qualification, each pin and alarm source individually enabled
    wire bkp_wake = |(pin_evt & wkup_ff[15:0])
        || (i_sm_alarm && wkup_ff[WKUP_SM_BIT])
        || (i_rtc_alarm && wkup_ff[WKUP_RTC_BIT])
        || (i_rtt_alarm && wkup_ff[WKUP_RTT_BIT]);
    wire wait_wake = |(pin_evt & fsmr_ff[15:0])
        || (i_rtc_alarm && fsmr_ff[FSMR_RTC_BIT])
        || (i_rtt_alarm && fsmr_ff[FSMR_RTT_BIT]);
    wire sleep_wake = wfi_entry_ff ? i_irq_pending
        : (i_irq_pending || i_event || wait_wake);

    // read data selection
    wire [31:0] stat_word = {23'h0, wfi_entry_ff, 1'b0, st_ff};
    wire [31:0] rd_mux = adr == ADDR_CTRL ? ctrl_ff
        : adr == ADDR_FSMR ? fsmr_ff
        : adr == ADDR_WKUP ? wkup_ff
        : adr == ADDR_PCER ? {24'h0, pcer_ff}
        : adr == ADDR_STAT ? stat_word
        : adr == ADDR_ISR ? {29'h0, isr_ff}
        : adr == ADDR_IMR ? {29'h0, imr_ff}
        : 32'h0000_0000;

    // wake pin filters
    for (genvar gi = 0; gi < 16; gi++) begin : g_pin
        lpmc_debounce u_deb (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_ce(i_ce),
            .i_pin(i_wakeup_pins[gi]),
            .i_len(deb_len),
            .o_evt(pin_evt[gi])
        );
    end

    // mode selection and sequencing
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_ACTIVE: begin
                if ((i_wfe || i_wfi) && deep)
                    nxt_st = ST_BACKUP;
                else if (i_wfe && low_power_mode_bit)
                    nxt_st = ST_WSYNC;
                else if (i_wfe || i_wfi)
                    nxt_st = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (sleep_wake)
                    nxt_st = ST_ACTIVE;
            end
            ST_WSYNC: begin
                if (resync_done)
                    nxt_st = ST_WAIT;
            end
            ST_WAIT: begin
                if (wait_wake)
                    nxt_st = ST_WRES;
            end
            ST_WRES: begin
                if (wres_done)
                    nxt_st = ST_ACTIVE;
            end
            ST_BACKUP: begin
                if (bkp_wake)
                    nxt_st = ST_BWAKE;
            end
            ST_BWAKE: begin
                if (bkp_done)
                    nxt_st = ST_ACTIVE;
            end
            default: nxt_st = ST_ACTIVE;
        endcase
    end

    // entry strobes for the sequence timers and the core register clear on backup entry
    wire go_sync = st_ff != ST_WSYNC && nxt_st == ST_WSYNC;
    wire go_wres = st_ff != ST_WRES && nxt_st == ST_WRES;
    wire go_bwake = st_ff != ST_BWAKE && nxt_st == ST_BWAKE;
    wire enter_bkp = st_ff != ST_BACKUP && nxt_st == ST_BACKUP;

    lpmc_timer u_resync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_start(go_sync),
        .i_load(RESYNC_CYC),
        .o_done(resync_done)
    );
    lpmc_timer u_wres (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_start(go_wres),
        .i_load(WRES_CYC),
        .o_done(wres_done)
    );
    lpmc_timer u_bwake (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_start(go_bwake),
        .i_load(BKP_CYC),
        .o_done(bkp_done)
    );

    // next output levels from the next state
    wire n_run = nxt_st == ST_ACTIVE;
    wire n_slp = nxt_st == ST_SLEEP;
    wire n_bkp = nxt_st == ST_BACKUP;
    wire n_bwk = nxt_st == ST_BWAKE;
    wire n_lowclk = nxt_st == ST_WSYNC || nxt_st == ST_WAIT || nxt_st == ST_WRES;
    wire nxt_core_clk = n_run;
    wire nxt_mem_clk = n_run || n_slp;
    wire [7:0] nxt_pclk = (n_run || n_slp) ? pcer_ff : 8'h00;
    wire [1:0] nxt_csrc = (n_lowclk || n_bwk) ? CSEL_FAST_RC : csel;
    wire nxt_power = !n_bkp;
    wire nxt_rst = n_bkp || n_bwk;
    wire nxt_hold = n_bkp;
    wire nxt_pull = n_bwk;

    // interrupt status, a new event wins over a clearing write
    wire [2:0] isr_set = {st_ff == ST_BWAKE && bkp_done,
        st_ff == ST_WRES && wres_done,
        st_ff == ST_SLEEP && sleep_wake};
    wire [2:0] isr_clr = wr_isr ? i_avs_writedata[2:0] : 3'h0;
    wire [2:0] nxt_isr = (isr_ff & ~isr_clr) | isr_set;
    wire nxt_irq = |(nxt_isr & imr_ff);

    // bus handshake: waitrequest drops for one cycle per request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if (i_ce) begin
            wait_ff <= !(req && wait_ff);
            rdata_ff <= (req && wait_ff) ? rd_mux : rdata_ff;
        end
    end

    // core-domain control registers, lost when backup is entered
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_ff <= CTRL_RST;
            fsmr_ff <= FSMR_RST;
            pcer_ff <= PCER_RST;
        end else if (i_ce) begin
            ctrl_ff <= enter_bkp ? CTRL_RST : (wr_ctrl ? i_avs_writedata : ctrl_ff);
            fsmr_ff <= enter_bkp ? FSMR_RST : (wr_fsmr ? i_avs_writedata : fsmr_ff);
            pcer_ff <= enter_bkp ? PCER_RST : (wr_pcer ? i_avs_writedata[7:0] : pcer_ff);
        end
    end

    // backup-domain wake enables and interrupt registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wkup_ff <= WKUP_RST;
            imr_ff <= IMR_RST;
            isr_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else if (i_ce) begin
            wkup_ff <= wr_wkup ? i_avs_writedata : wkup_ff;
            imr_ff <= wr_imr ? i_avs_writedata[2:0] : imr_ff;
            isr_ff <= nxt_isr;
            irq_ff <= nxt_irq;
        end
    end

    // state, entry kind and cycles spent in backup wake
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_ff <= ST_ACTIVE;
            wfi_entry_ff <= 1'b0;
            bwk_cnt_ff <= 12'h000;
        end else if (i_ce) begin
            st_ff <= nxt_st;
            bwk_cnt_ff <= (st_ff == ST_BWAKE) ? bwk_cnt_ff + 12'h001 : 12'h000;
            wfi_entry_ff <= (st_ff == ST_ACTIVE && n_slp) ? i_wfi && !i_wfe : wfi_entry_ff;
        end
    end

    // registered clock and power outputs
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            core_clk_ff <= 1'b1;
            mem_clk_ff <= 1'b1;
            pclk_ff <= PCER_RST;
            csrc_ff <= CSEL_FAST_RC;
            reg_ff <= 1'b1;
            sup_ff <= 1'b1;
        end else if (i_ce) begin
            core_clk_ff <= nxt_core_clk;
            mem_clk_ff <= nxt_mem_clk;
            pclk_ff <= nxt_pclk;
            csrc_ff <= nxt_csrc;
            reg_ff <= nxt_power;
            sup_ff <= nxt_power;
        end
    end

    // registered reset and i/o control outputs
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_ff <= 1'b0;
            hold_ff <= 1'b0;
            pull_ff <= 1'b0;
        end else if (i_ce) begin
            rst_ff <= nxt_rst;
            hold_ff <= nxt_hold;
            pull_ff <= nxt_pull;
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_core_clk_en = core_clk_ff;
    assign o_mem_clk_en = mem_clk_ff;
    assign o_periph_clk_en = pclk_ff;
    assign o_clk_src = csrc_ff;
    assign o_regulator_en = reg_ff;
    assign o_core_supply_en = sup_ff;
    assign o_backup_dom_en = 1'b1;
    assign o_core_rst = rst_ff;
    assign o_io_hold = hold_ff;
    assign o_io_pullup_force = pull_ff;
    assign o_irq = irq_ff;

    // checks
    sequence s_wait_wake;
        st_ff == ST_WAIT && wait_wake && i_ce;
    endsequence
    sequence s_resumed;
        st_ff == ST_WRES ##[1:WRES_MAX] st_ff == ST_ACTIVE;
    endsequence
    sequence s_bkp_wake;
        st_ff == ST_BACKUP && bkp_wake && i_ce;
    endsequence
    sequence s_bkp_out;
        o_core_rst && o_io_pullup_force && st_ff == ST_BWAKE;
    endsequence
    AST_BKP_ENTRY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_ACTIVE && i_wfe && deep && i_ce |=> st_ff == ST_BACKUP && o_io_hold)
        else $error("deep sleep event did not enter backup");
    AST_WAIT_ENTRY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_ACTIVE && i_wfe && !deep && low_power_mode_bit && i_ce |=> st_ff == ST_WSYNC)
        else $error("low power event did not start wait entry");
    AST_SLEEP_ENTRY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_ACTIVE && (i_wfe || i_wfi) && !deep && !low_power_mode_bit && i_ce
        |=> st_ff == ST_SLEEP && !o_core_clk_en)
        else $error("sleep instruction did not enter sleep");
    AST_WAIT_CLK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_WAIT |-> !o_core_clk_en && !o_mem_clk_en && o_periph_clk_en == 8'h00
        && o_regulator_en && o_core_supply_en && o_clk_src == CSEL_FAST_RC)
        else $error("wait mode clocks or supplies wrong");
    AST_BKP_SUPPLY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_BACKUP |-> !o_regulator_en && !o_core_supply_en && o_backup_dom_en)
        else $error("backup supplies wrong");
    AST_IO_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_BACKUP |-> o_io_hold && !o_io_pullup_force)
        else $error("i/o hold not kept in backup");
    AST_WAIT_RESUME: assert property (@(posedge i_clk) disable iff (i_sys_rst || !i_ce)
        s_wait_wake |=> s_resumed)
        else $error("wait resume too slow");
    AST_BKP_WAKE: assert property (@(posedge i_clk) disable iff (i_sys_rst || !i_ce)
        s_bkp_wake |=> s_bkp_out)
        else $error("backup wake did not begin");
    AST_BKP_TIME: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_BWAKE |-> bwk_cnt_ff < BKP_CYC && o_core_rst)
        else $error("backup wake too slow");
    AST_SLEEP_WFI: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_SLEEP && wfi_entry_ff && !i_irq_pending |=> st_ff == ST_SLEEP)
        else $error("interrupt-only sleep woke without interrupt");
    AST_SLEEP_CLK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff == ST_SLEEP |-> !o_core_clk_en && o_mem_clk_en && o_periph_clk_en == $past(pcer_ff))
        else $error("sleep clocks wrong");
endmodule : lpmc_top

// [verification/lpmc_core_model.sv]
// lpmc_core_model: processor core that executes sleep instructions.
// assumes the bench requests a sleep with a one-cycle strobe.
`timescale 1ns/10ps
module lpmc_core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // core clock gate from the controller
    input wire logic i_core_clk_en,
    // bench commands
    input wire logic i_sleep_req,
    input wire logic i_use_wfi,
    input wire logic i_irq_req,
    // instruction strobes and pending interrupt
    output logic o_wfe,
    output logic o_wfi,
    output logic o_irq_pending
);
    // a stopped core executes nothing, so strobes need a running clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wfe <= 1'b0;
            o_wfi <= 1'b0;
            o_irq_pending <= 1'b0;
        end else begin
            o_wfe <= i_sleep_req & ~i_use_wfi & i_core_clk_en;
            o_wfi <= i_sleep_req & i_use_wfi & i_core_clk_en;
            o_irq_pending <= i_irq_req;
        end
    end
endmodule : lpmc_core_model

// [verification/lpmc_top_test.sv]
// lpmc_top_test: bus, sleep, wait and backup tests of the controller.
// assumes lpmc_core_model drives the sleep strobes; 25 MHz clock.
`timescale 1ns/10ps
module lpmc_top_test;
    import lpmc_pkg::*;
    logic i_clk = 0;
    logic i_sys_rst = 1;
    logic [4:0] adr = '0;
    logic rd = 0, wr = 0, req = 0, use_wfi = 0, irq_req = 0, evt = 0;
    logic sm = 0, rtc = 0, real_time_timer = 0;
    logic [15:0] pins = '0;
    logic [31:0] wdat = '0, rdata, q;
    logic wreq, wait_for_event_instr, wait_for_interrupt_instr, irqp, core_clk, mem_clk, reg_en, sup_en, bkp_en;
    logic core_rst, io_hold, pull, irq;
    logic [7:0] pclk;
    logic [1:0] csrc;
    int bad_count = 0, n_tests = 0, cyc = 0, n;
    always #20 i_clk = ~i_clk;
    lpmc_core_model i_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_core_clk_en(core_clk),
        .i_sleep_req(req), .i_use_wfi(use_wfi), .i_irq_req(irq_req),
        .o_wfe(wait_for_event_instr), .o_wfi(wait_for_interrupt_instr), .o_irq_pending(irqp));
    lpmc_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_wfe(wait_for_event_instr), .i_wfi(wait_for_interrupt_instr),
        .i_irq_pending(irqp), .i_event(evt), .i_wakeup_pins(pins), .i_sm_alarm(sm),
        .i_rtc_alarm(rtc), .i_rtt_alarm(real_time_timer), .o_core_clk_en(core_clk),
        .o_mem_clk_en(mem_clk), .o_periph_clk_en(pclk), .o_clk_src(csrc),
        .o_regulator_en(reg_en), .o_core_supply_en(sup_en), .o_backup_dom_en(bkp_en),
        .o_core_rst(core_rst), .o_io_hold(io_hold), .o_io_pullup_force(pull), .o_irq(irq));
    // hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end
    task automatic close_out;
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        @(posedge i_clk);
        while (wreq !== 1'b0) @(posedge i_clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask : rchk
    // one sleep instruction, then outputs settled
    task automatic sleep(input logic w);
        @(posedge i_clk);
        req <= 1'b1;
        use_wfi <= w;
        @(posedge i_clk);
        req <= 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask : sleep
    function automatic logic pick(input int s);
        return (s == 0) ? core_clk : core_rst;
    endfunction : pick
    // bounded wait for the core clock or core reset to reach a level
    task automatic wait_for(input int s, input logic v, input int mx);
        n = 0;
        @(negedge i_clk);
        while (pick(s) !== v && n < mx) begin
            @(negedge i_clk);
            n++;
        end
    endtask : wait_for
    initial begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        chk({core_clk, mem_clk, reg_en, sup_en, bkp_en, core_rst, io_hold, pull}, 8'hF8);
        rchk(ADDR_CTRL, CTRL_RST);
        rchk(ADDR_STAT, 32'h0000_0001);
        rchk(5'h1C, 32'h0000_0000);
        bus(1'b1, ADDR_PCER, 32'h0000_00A5);
        bus(1'b1, ADDR_CTRL, 32'h0000_000C);
        bus(1'b1, ADDR_IMR, 32'h0000_0007);
        @(negedge i_clk);
        chk({pclk, csrc}, 10'h296);
        // sleep by wfi ignores events, wakes on interrupt
        sleep(1'b1);
        chk({core_clk, mem_clk, pclk}, 10'h1A5);
        rchk(ADDR_STAT, 32'h0000_0102);
        evt <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk(core_clk, 1'b0);
        evt <= 1'b0;
        irq_req <= 1'b1;
        wait_for(0, 1'b1, 10);
        chk(n < 10, 1'b1);
        irq_req <= 1'b0;
        rchk(ADDR_ISR, 32'h0000_0001);
        @(negedge i_clk);
        chk(irq, 1'b1);
        bus(1'b1, ADDR_ISR, 32'h0000_0001);
        rchk(ADDR_ISR, 32'h0000_0000);
        @(negedge i_clk);
        chk(irq, 1'b0);
        // sleep by wfe wakes on an event
        sleep(1'b0);
        rchk(ADDR_STAT, 32'h0000_0002);
        evt <= 1'b1;
        wait_for(0, 1'b1, 10);
        chk(n < 10, 1'b1);
        @(posedge i_clk);
        evt <= 1'b0;
        bus(1'b1, ADDR_ISR, 32'h0000_0007);
        // wait mode: fast rc, low power bit, then wfe; pin 3 and rtc enabled
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        rchk(ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_WKUP, 32'h0000_0000);
        bus(1'b1, ADDR_FSMR, 32'h0012_0008);
        for (int k = 0; k < 2; k++) begin
            sleep(1'b0);
            chk({core_clk, mem_clk, pclk, reg_en, sup_en, csrc}, 14'h000C);
            repeat (6) @(posedge i_clk);
            rchk(ADDR_STAT, 32'h0000_0008);
            real_time_timer <= 1'b1;
            repeat (20) @(posedge i_clk);
            chk(core_clk, 1'b0);
            real_time_timer <= 1'b0;
            if (k == 0) pins[3] <= 1'b1;
            else rtc <= 1'b1;
            wait_for(0, 1'b1, 300);
            chk(n >= 240 && n <= 254, 1'b1);
            chk({pclk, csrc, io_hold, mem_clk}, 12'hA51);
            rchk(ADDR_ISR, 32'h0000_0002);
            bus(1'b1, ADDR_ISR, 32'h0000_0007);
            pins <= '0;
            rtc <= 1'b0;
        end
        // backup entry and wake from each source
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, ADDR_WKUP, (s == 0) ? 32'h0000_0080 : 32'h0000_0001 << (15 + s));
            bus(1'b1, ADDR_CTRL, 32'h0000_0001);
            bus(1'b1, ADDR_FSMR, (s == 0) ? 32'h0010_0000 : 32'h0000_0000);
            sleep(1'b0);
            chk({reg_en, sup_en, bkp_en, core_rst, io_hold, core_clk}, 6'h0E);
            @(posedge i_clk);
            case (s)
                0: pins[7] <= 1'b1;
                1: sm <= 1'b1;
                2: rtc <= 1'b1;
                default: real_time_timer <= 1'b1;
            endcase
            repeat (20) @(posedge i_clk);
            @(negedge i_clk);
            chk({pull, core_rst, reg_en}, 3'h7);
            wait_for(1, 1'b0, 2600);
            chk(n >= 2380 && n <= 2480, 1'b1);
            chk({pull, io_hold, core_clk}, 3'h1);
            rchk(ADDR_CTRL, CTRL_RST);
            rchk(ADDR_ISR, 32'h0000_0004);
            bus(1'b1, ADDR_ISR, 32'h0000_0007);
            pins <= '0;
            {sm, rtc, real_time_timer} <= 3'h0;
        end
        close_out();
    end
endmodule : lpmc_top_test
